// >>> tsp_core_model.sv
// core stand-in: watchdog time base ticks and clear instructions
// assumes one clock, clear requests from the bench
`timescale 1ns/1ps

module tsp_core_model (
  input  wire logic i_ref_clk, // instruction clock
  input  wire logic i_rst_n,   // async reset, active low
  input  wire logic i_clr_req, // issue one clear
  output logic      o_tick,    // time base tick
  output logic      o_clear    // clear instruction
);
  logic [1:0] div;

  // one tick every third cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div    <= 2'h0;
      o_tick <= 1'b0;
    end else begin
      div    <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      o_tick <= (div == 2'h2);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_clear <= 1'b0;
    end else begin
      o_clear <= i_clr_req;
    end
  end
endmodule

// >>> tsp_map.svh
// register map, field positions and reset values of the base timer block
// assumes inclusion by the package, the prescaler, the top module and the bench
`ifndef TSP_MAP_SVH
`define TSP_MAP_SVH

// register addresses on the plain port
`define TSP_AW          3
`define TSP_ADDR_CFG    3'h0
`define TSP_ADDR_COUNT  3'h1
`define TSP_ADDR_CTRL   3'h2
`define TSP_ADDR_STATUS 3'h3
`define TSP_ADDR_MASK   3'h4

// configuration fields
`define TSP_CFG_W       6
`define TSP_CFG_RST     6'h3f
`define TSP_CFG_SRC     5
`define TSP_CFG_EDGE    4
`define TSP_CFG_TGT     3
`define TSP_CFG_PS_HI   2
`define TSP_CFG_PS_LO   0

// status, mask and control fields
`define TSP_EV_W        2
`define TSP_EV_OVF      0
`define TSP_EV_WDT      1
`define TSP_CTRL_GIE    0

// counts and constants
`define TSP_CNT_MAX     8'hff
`define TSP_CNT_ZERO    8'h00
`define TSP_PRE_ZERO    8'h00
`define TSP_PRE_ONE     8'h01

`endif

// >>> tsp_phase_sync.sv
// internal phase counter and sampling of the prescaler output on phases two and four
// assumes the external pin is already synchronous to the clock
`timescale 1ns/1ps

module tsp_phase_sync (
  input  wire logic i_ref_clk,  // instruction clock
  input  wire logic i_rst_n,    // async reset, active low
  input  wire logic i_ext_clk,  // external count clock pin
  input  wire logic i_fall,     // count on falling edge
  input  wire logic i_pre_out,  // prescaler output to sample
  output logic      o_ext_evt,  // edge seen on the pin
  output logic      o_sample    // sampled count pulse
);
  import tsp_pkg::*;

  tsp_phase_t phase;
  tsp_phase_t next_phase;
  logic       pin_q;
  logic       pend;
  logic       at_sample;

  // phase walk
  always_comb begin
    case (phase)
      TSP_Q1:  next_phase = TSP_Q2;
      TSP_Q2:  next_phase = TSP_Q3;
      TSP_Q3:  next_phase = TSP_Q4;
      TSP_Q4:  next_phase = TSP_Q1;
      default: next_phase = TSP_Q1;
    endcase
  end

  assign at_sample = (phase == TSP_Q2) || (phase == TSP_Q4);
  assign o_ext_evt = i_fall ? (pin_q & ~i_ext_clk) : (~pin_q & i_ext_clk);

  // RULE16 sample on phases two and four
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase    <= TSP_Q1;
      pin_q    <= 1'b0;
      pend     <= 1'b0;
      o_sample <= 1'b0;
    end else begin
      phase    <= next_phase;
      pin_q    <= i_ext_clk;
      pend     <= at_sample ? 1'b0 : (pend | i_pre_out);
      o_sample <= at_sample & (pend | i_pre_out);
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  phase_sample_a: assert property (o_sample |-> $past(phase) inside {TSP_Q2, TSP_Q4}) // RULE16
    else $error("count sampled outside phase two or four");
endmodule

// >>> tsp_pkg.sv
// types and shared functions of the base timer block
// assumes the map header is on the include path
`include "tsp_map.svh"

package tsp_pkg;

  typedef logic [7:0] tsp_byte_t;
  typedef logic [`TSP_AW-1:0] tsp_addr_t;
  typedef logic [2:0] tsp_ps_t;

  // internal phases, gray along the cycle
  typedef enum logic [1:0] {
    TSP_Q1 = 2'b00,
    TSP_Q2 = 2'b01,
    TSP_Q3 = 2'b11,
    TSP_Q4 = 2'b10
  } tsp_phase_t;

  // last prescaler count before its output pulse
  function automatic tsp_byte_t tsp_term(input tsp_ps_t sel, input logic to_wdt);
    tsp_byte_t ratio;
    ratio = `TSP_PRE_ONE << sel;
    if (!to_wdt) begin
      ratio = ratio << 1;
    end
    return ratio - `TSP_PRE_ONE;
  endfunction

endpackage

// >>> tsp_pre_if.sv
// signals between the timer top and its shared prescaler
// assumes one clock domain on both sides
`timescale 1ns/1ps

interface tsp_pre_if;
  import tsp_pkg::*;
  logic    clr;    // clear prescaler count
  logic    tick;   // input event
  logic    to_wdt; // prescaler serves the watchdog
  tsp_ps_t sel;    // prescale select
  logic    pulse;  // prescaler output pulse

  modport ctl (output clr, output tick, output to_wdt, output sel, input pulse);
  modport pre (input clr, input tick, input to_wdt, input sel, output pulse);
endinterface

// >>> tsp_prescaler.sv
// shared prescaler: counts input events, pulses at the selected ratio
// assumes the top routes tick and pulse to exactly one user
`timescale 1ns/1ps
`include "tsp_map.svh"

module tsp_prescaler (
  input wire logic i_ref_clk, // instruction clock
  input wire logic i_rst_n,   // async reset, active low
  tsp_pre_if.pre   p          // control and output
);
  import tsp_pkg::*;

  tsp_byte_t cnt;
  tsp_byte_t term;

  // RULE17 ratio from select
  assign term = tsp_term(p.sel, p.to_wdt);
  assign p.pulse = p.tick & ~p.clr & (cnt >= term);

  // count not reachable from software
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= `TSP_PRE_ZERO;
    end else if (p.clr) begin
      cnt <= `TSP_PRE_ZERO;
    end else if (p.tick) begin
      cnt <= (cnt >= term) ? `TSP_PRE_ZERO : cnt + `TSP_PRE_ONE;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  pre_clear_a: assert property (p.clr |=> cnt == `TSP_PRE_ZERO) // RULE6
    else $error("prescaler not cleared");
  pre_ratio_a: assert property (p.pulse |-> cnt == term && $stable(term) || cnt >= term) // RULE17
    else $error("prescaler pulse at wrong count");
endmodule

// >>> tsp_timer.sv
// base timer with a prescaler shared with the watchdog, registers and interrupt
// assumes a plain register port, inputs synchronous to the clock
//
// Contract
// RULE1: one prescaler, never serving both users
// RULE2: target bit 0 timer, 1 watchdog
// RULE3: three select bits give eight timer ratios
// RULE4: timer undivided only when prescaler on watchdog
// RULE5: prescaler count has no register access
// RULE6: count write clears prescaler when timer owns
// RULE7: watchdog clear also clears prescaler when watchdog owns
// RULE8: software order moving prescaler to watchdog
// RULE9: software order moving prescaler to timer
// RULE10: wrap from ff to 00 requests interrupt
// RULE11: overflow flag set on every wrap
// RULE12: software alone clears the overflow flag
// RULE13: overflow interrupt gated by its enable
// RULE14: global enable gates every interrupt
// RULE15: timer frozen during sleep
// RULE16: counter mode samples on phases two, four
// RULE17: timer ratio is two to n plus one
// RULE18: count advances once per prescaler pulse
`timescale 1ns/1ps
`include "tsp_map.svh"

module tsp_timer #(
  parameter int WDT_W = 8 // watchdog count width
) (
  input  wire logic              i_ref_clk,     // instruction clock
  input  wire logic              i_rst_n,       // async reset, active low
  input  wire tsp_pkg::tsp_addr_t i_addr,       // register address
  input  wire tsp_pkg::tsp_byte_t i_wdata,      // write data
  input  wire logic              i_wr,          // write strobe
  input  wire logic              i_rd,          // read strobe
  output tsp_pkg::tsp_byte_t     o_rdata,       // read data, next cycle
  input  wire logic              i_sleep,       // core is asleep
  input  wire logic              i_ext_clk,     // external count clock
  input  wire logic              i_wdt_tick,    // watchdog oscillator tick
  input  wire logic              i_wdt_clear,   // watchdog clear instruction
  output logic                   o_irq,         // interrupt level
  output logic                   o_wdt_timeout  // watchdog expiry pulse
);
  import tsp_pkg::*;

  // registers
  logic [`TSP_CFG_W-1:0] cfg;
  tsp_byte_t             count;
  logic                  global_irq_enable;
  logic [`TSP_EV_W-1:0]  status;
  logic [`TSP_EV_W-1:0]  mask;
  logic [WDT_W-1:0]      wdt_cnt;

  // decoded strobes
  logic wr_cfg;
  logic wr_count;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;

  // datapath
  logic to_wdt;
  logic cnt_mode;
  logic ext_evt;
  logic timer_evt;
  logic direct;
  logic pre_out_t;
  logic sampled;
  logic inc;
  logic wdt_step;
  logic wrap;
  logic wdt_expire;
  logic [`TSP_EV_W-1:0] ev_set;

  tsp_pre_if pre ();

  // address decode of write strobes
  assign wr_cfg    = i_wr && (i_addr == `TSP_ADDR_CFG);
  assign wr_count  = i_wr && (i_addr == `TSP_ADDR_COUNT);
  assign wr_ctrl   = i_wr && (i_addr == `TSP_ADDR_CTRL);
  assign wr_status = i_wr && (i_addr == `TSP_ADDR_STATUS);
  assign wr_mask   = i_wr && (i_addr == `TSP_ADDR_MASK);

  // RULE2 prescaler target
  assign to_wdt   = cfg[`TSP_CFG_TGT];
  assign cnt_mode = cfg[`TSP_CFG_SRC];

  // RULE15 no timer events in sleep
  assign timer_evt = ~i_sleep & (cnt_mode ? ext_evt : 1'b1);

  // RULE1 prescaler input from one user only
  assign pre.tick   = to_wdt ? i_wdt_tick : timer_evt;
  assign pre.to_wdt = to_wdt;
  // RULE3 select field to prescaler
  assign pre.sel    = cfg[`TSP_CFG_PS_HI:`TSP_CFG_PS_LO];

  // RULE6 RULE7 prescaler clear by owner
  assign pre.clr = (wr_count & ~to_wdt) | (i_wdt_clear & to_wdt);

  // RULE4 undivided events when prescaler on watchdog
  assign direct    = to_wdt & timer_evt;
  assign pre_out_t = ~to_wdt & pre.pulse;

  // RULE18 one count per pulse, sampled in counter mode
  assign inc  = ~i_sleep & (cnt_mode ? sampled : (pre_out_t | direct));
  assign wrap = inc & ~wr_count & (count == `TSP_CNT_MAX);

  // watchdog takes the prescaler output only while it owns it
  assign wdt_step   = to_wdt ? pre.pulse : i_wdt_tick;
  assign wdt_expire = wdt_step & ~i_wdt_clear & (&wdt_cnt);

  assign ev_set = {wdt_expire, wrap};

  tsp_prescaler u_pre (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .p         (pre)
  );

  tsp_phase_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_ext_clk (i_ext_clk),
    .i_fall    (cfg[`TSP_CFG_EDGE]),
    .i_pre_out (pre_out_t | direct),
    .o_ext_evt (ext_evt),
    .o_sample  (sampled)
  );

  // configuration register
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg <= `TSP_CFG_RST;
    end else if (wr_cfg) begin
      cfg <= i_wdata[`TSP_CFG_W-1:0];
    end
  end

  // RULE10 count wraps ff to 00, write wins
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= `TSP_CNT_ZERO;
    end else if (wr_count) begin
      count <= i_wdata;
    end else if (inc) begin
      count <= count + `TSP_PRE_ONE;
    end
  end

  // global enable and mask
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      global_irq_enable  <= 1'b0;
      mask <= '0;
    end else begin
      if (wr_ctrl) begin
        global_irq_enable <= i_wdata[`TSP_CTRL_GIE];
      end
      if (wr_mask) begin
        mask <= i_wdata[`TSP_EV_W-1:0];
      end
    end
  end

  // RULE11 RULE12 sticky flags, set wins over clear
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~(wr_status ? i_wdata[`TSP_EV_W-1:0] : '0)) | ev_set;
    end
  end

  // RULE7 watchdog count and expiry
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdt_cnt       <= '0;
      o_wdt_timeout <= 1'b0;
    end else begin
      o_wdt_timeout <= wdt_expire;
      if (i_wdt_clear) begin
        wdt_cnt <= '0;
      end else if (wdt_step) begin
        wdt_cnt <= wdt_cnt + 1'b1;
      end
    end
  end

  // RULE13 RULE14 interrupt level
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= global_irq_enable & (|(status & mask));
    end
  end

  // read mux; RULE5 prescaler count is never shown
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `TSP_CNT_ZERO;
    end else if (i_rd) begin
      case (i_addr)
        `TSP_ADDR_CFG:    o_rdata <= {2'h0, cfg};
        `TSP_ADDR_COUNT:  o_rdata <= count;
        `TSP_ADDR_CTRL:   o_rdata <= {7'h00, global_irq_enable};
        `TSP_ADDR_STATUS: o_rdata <= {6'h00, status};
        `TSP_ADDR_MASK:   o_rdata <= {6'h00, mask};
        default:          o_rdata <= `TSP_CNT_ZERO;
      endcase
    end else begin
      o_rdata <= `TSP_CNT_ZERO;
    end
  end

  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_wrap;
    inc && !wr_count && (count == `TSP_CNT_MAX);
  endsequence

  sequence s_undivided;
    to_wdt && !cnt_mode && !i_sleep && !wr_count && !wr_cfg;
  endsequence

  wrap_zero_a: assert property (s_wrap |=> count == `TSP_CNT_ZERO) // RULE10
    else $error("count did not wrap to zero");

  ovf_flag_a: assert property (s_wrap |=> status[`TSP_EV_OVF]) // RULE11
    else $error("overflow flag not set on wrap");

  flag_hold_a: assert property ( // RULE12
    status[`TSP_EV_OVF] && !wr_status |=> status[`TSP_EV_OVF])
    else $error("overflow flag cleared without software");

  irq_mask_a: assert property ( // RULE13
    global_irq_enable && status == 2'h1 && !mask[`TSP_EV_OVF] ##1 $stable(mask) |=> !o_irq)
    else $error("masked overflow raised interrupt");

  irq_gie_a: assert property (!global_irq_enable ##1 !global_irq_enable |=> !o_irq) // RULE14
    else $error("interrupt raised with global enable clear");

  irq_raise_a: assert property ( // RULE13
    global_irq_enable && status[`TSP_EV_OVF] && mask[`TSP_EV_OVF] |=> o_irq)
    else $error("enabled overflow did not raise interrupt");

  sleep_freeze_a: assert property (i_sleep && !wr_count |=> $stable(count)) // RULE15
    else $error("count moved during sleep");

  one_to_one_a: assert property ( // RULE4
    s_undivided |=> count == $past(count) + `TSP_PRE_ONE)
    else $error("timer not undivided with prescaler on watchdog");

  pre_owner_a: assert property ( // RULE1
    pre.pulse |-> (to_wdt ? !pre_out_t : !wdt_step || i_wdt_tick))
    else $error("prescaler output reached both users");

  wdt_clear_a: assert property (i_wdt_clear |=> wdt_cnt == '0 && !o_wdt_timeout) // RULE7
    else $error("watchdog not cleared");

  write_wins_a: assert property (wr_count |=> count == $past(i_wdata)) // RULE6
    else $error("count write lost");

  read_data_a: assert property (i_rd && i_addr == `TSP_ADDR_COUNT |=> o_rdata == $past(count)) // RULE5
    else $error("count read returned wrong value");

endmodule

// >>> tsp_timer_tb_top.sv
// bench of the base timer: register port tasks, register model, checks
// assumes the core stand-in supplies watchdog ticks and clears
`timescale 1ns/1ps
`include "tsp_map.svh"

module tsp_timer_tb_top;
  import tsp_pkg::*;
  localparam int WW = 2; // short watchdog
  logic        i_ref_clk;
  logic        i_rst_n;
  logic        i_wr;
  logic        i_rd;
  logic        i_sleep;
  logic        i_ext_clk;
  logic        clr_req;
  logic        tick;
  logic        wclr;
  logic        o_irq;
  logic        o_wdt_timeout;
  tsp_addr_t   i_addr;
  tsp_byte_t   i_wdata;
  tsp_byte_t   o_rdata;
  tsp_byte_t   r;
  tsp_byte_t   v;
  tsp_byte_t   ec[3] = '{8'h28, 8'h38, 8'h20};
  logic [31:0] seed = 32'h5810;
  int          bad_count, checks, d, g, l0, n, k;
  int          mdl[8] = '{'h3f, 0, 0, 0, 0, 0, 0, 0};
  int          wm[8] = '{'h3f, 0, 'h01, 0, 'h03, 0, 0, 0};

  tsp_timer #(.WDT_W(WW)) tsp_timer_i (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_sleep(i_sleep), .i_ext_clk(i_ext_clk), .i_wdt_tick(tick),
    .i_wdt_clear(wclr), .o_irq(o_irq), .o_wdt_timeout(o_wdt_timeout));
  tsp_core_model tsp_core_model_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_clr_req(clr_req), .o_tick(tick), .o_clear(wclr));

  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // a wait bound used up
  task automatic hang();
    chk(16'h0, 16'h1);
    complete_run();
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge i_ref_clk);
  endtask

  task automatic wr(input tsp_addr_t a, input tsp_byte_t dv);
    @(posedge i_ref_clk);
    i_addr  <= a;
    i_wdata <= dv;
    i_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_wr   <= 1'b0;
    mdl[a] = dv & wm[a];
  endtask

  task automatic rd(input tsp_addr_t a, output tsp_byte_t dv);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    @(negedge i_ref_clk);
    dv = o_rdata;
  endtask

  // read a register and compare with the model
  task automatic rc(input tsp_addr_t a);
    rd(a, r);
    chk(r, 16'(mdl[a]));
  endtask

  task automatic clr();
    @(posedge i_ref_clk);
    clr_req <= 1'b1;
    @(posedge i_ref_clk);
    clr_req <= 1'b0;
  endtask

  task automatic irq_is(input logic e);
    cyc(3);
    @(negedge i_ref_clk);
    chk(o_irq, e);
  endtask

  // poll the count every cycle: first value, delay to first step, step gap
  task automatic poll(output tsp_byte_t p0, output int d0, output int gap);
    tsp_byte_t p, df;
    int c, m;
    @(posedge i_ref_clk);
    i_addr <= `TSP_ADDR_COUNT;
    i_rd   <= 1'b1;
    @(negedge i_ref_clk);
    @(negedge i_ref_clk);
    p  = o_rdata;
    p0 = p;
    c  = 0;
    m  = 0;
    for (int t = 0; t < 1200 && m < 3; t++) begin
      @(negedge i_ref_clk);
      c++;
      if (o_rdata !== p) begin
        df = o_rdata - p;
        chk(df, 8'h01); // one step per pulse
        if (m == 0) d0 = c;
        m++;
        gap = c;
        c   = 0;
        p   = o_rdata;
      end
    end
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    if (m < 3) hang();
  endtask

  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    cyc(90000);
    hang();
  end

  initial begin
    {i_rst_n, i_wr, i_rd, i_sleep, i_ext_clk, clr_req} = 6'h00;
    i_addr  = `TSP_ADDR_CFG;
    i_wdata = 8'h00;
    cyc(20);
    i_rst_n <= 1'b1;
    // reset values, unmapped writes ignored
    for (int a = 0; a < 8; a++) begin
      if (a > 4) wr(tsp_addr_t'(a), 8'hff);
      rc(tsp_addr_t'(a));
    end
    $display("map test done");
    // watchdog to timer, then every ratio from a random phase
    clr();
    for (int s = 0; s < 8; s++) begin
      wr(`TSP_ADDR_CFG, 8'(s));
      rc(`TSP_ADDR_CFG);
      cyc(rnd() % 200 + 1);
      v = 8'(rnd()) & 8'h7f;
      wr(`TSP_ADDR_COUNT, v);
      poll(r, d, g);
      chk(r, v);
      chk(16'(g), 16'(2 << s));
      if (s == 0) l0 = d - 2;
      chk(16'(d - (2 << s)), 16'(l0));
    end
    // timer to watchdog in the safe order
    clr();
    wr(`TSP_ADDR_COUNT, 8'h00);
    wr(`TSP_ADDR_CFG, 8'h0f);
    clr();
    wr(`TSP_ADDR_CFG, 8'h08);
    poll(r, d, g);
    chk(16'(g), 16'h1);
    $display("ratio test done");
    // overflow flag and interrupt gating
    wr(`TSP_ADDR_STATUS, 8'h01);
    wr(`TSP_ADDR_COUNT, 8'hff);
    cyc(4);
    rd(`TSP_ADDR_STATUS, r);
    chk(r & 8'h01, 8'h01);
    irq_is(1'b0);
    wr(`TSP_ADDR_MASK, 8'h01);
    rc(`TSP_ADDR_MASK);
    irq_is(1'b0);
    wr(`TSP_ADDR_CTRL, 8'h01);
    rc(`TSP_ADDR_CTRL);
    irq_is(1'b1);
    wr(`TSP_ADDR_MASK, 8'h00);
    irq_is(1'b0);
    wr(`TSP_ADDR_MASK, 8'h01);
    cyc(60);
    irq_is(1'b1);
    wr(`TSP_ADDR_STATUS, 8'h01);
    irq_is(1'b0);
    $display("interrupt test done");
    // frozen while asleep, runs again after
    @(posedge i_ref_clk);
    i_sleep <= 1'b1;
    cyc(3);
    rd(`TSP_ADDR_COUNT, r);
    cyc(20);
    rd(`TSP_ADDR_COUNT, v);
    chk(v, r);
    @(posedge i_ref_clk);
    i_sleep <= 1'b0;
    rd(`TSP_ADDR_COUNT, v);
    chk(16'(v == r), 16'h0);
    $display("sleep test done");
    // external pin on either edge, direct and through the prescaler
    foreach (ec[j]) begin
      wr(`TSP_ADDR_CFG, ec[j]);
      wr(`TSP_ADDR_COUNT, 8'h00);
      n = 0;
      repeat (9) begin
        cyc(rnd() % 8 + 4);
        i_ext_clk <= ~i_ext_clk;
        if (i_ext_clk == ec[j][4]) n++;
      end
      cyc(12);
      rd(`TSP_ADDR_COUNT, r);
      chk(r, 16'(n >> (ec[j][3] ? 0 : 1)));
    end
    $display("pin test done");
    // watchdog clear restarts watchdog and prescaler
    wr(`TSP_ADDR_CFG, 8'h09);
    repeat (3) begin
      cyc(rnd() % 7);
      k = 0;
      for (int t = 0; t < 10 && k == 0; t++) begin
        @(negedge i_ref_clk);
        if (tick === 1'b1) k = 1;
      end
      clr();
      n = 0;
      k = 0;
      for (int t = 0; t < 100 && k == 0; t++) begin
        @(negedge i_ref_clk);
        if (o_wdt_timeout === 1'b1) k = 1;
        else if (tick === 1'b1) n++;
      end
      if (k == 0) hang();
      chk(16'(n), 16'((1 << WW) << 1));
      rd(`TSP_ADDR_STATUS, r);
      chk(r & 8'h02, 8'h02);
    end
    $display("watchdog test done");
    complete_run();
  end
endmodule
